/* File: design/dsw_pkg.sv */
package dsw_pkg;

    // serial frame layout
    localparam int          FRAME_BITS  = 24;
    localparam logic [4:0]  LAST_BIT    = 5'h17;     // index of the 24th bit
    localparam logic [4:0]  GUARD_BITS  = 5'h08;     // upper byte received
    localparam logic [23:0] SOFT_WORD   = 24'hffffff;
    localparam logic [7:0]  SOFT_BYTE   = 8'hff;
    localparam int          MODE_HI     = 17;
    localparam int          MODE_LO     = 16;
    localparam int          CODE_W      = 16;

    // power-on output codes
    localparam logic [15:0] POR_ZERO    = 16'h0000;
    localparam logic [15:0] POR_MID     = 16'h8000;

    // output stage modes
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_OPEN   = 2'b01,
        MODE_R100K  = 2'b10,
        MODE_R1K    = 2'b11
    } dsw_mode_t;

    // frame states
    typedef enum logic [1:0] {
        ST_WAIT_HIGH = 2'b00,
        ST_IDLE      = 2'b01,
        ST_SHIFT     = 2'b10
    } dsw_state_t;

    // wake-up timing
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          WAKE_5V_NS    = 2500;
    localparam int          WAKE_3V_NS    = 5000;
    localparam logic [5:0]  WAKE_5V_CYC   = 6'((WAKE_5V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [5:0]  WAKE_3V_CYC   = 6'((WAKE_3V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // apb register map
    localparam int          ADDR_W      = 12;
    localparam logic [11:0] CTRL_OFS    = 12'h000;
    localparam logic [11:0] STATUS_OFS  = 12'h004;
    localparam logic [11:0] COUNT_OFS   = 12'h008;
    localparam logic [1:0]  CTRL_RST    = 2'h0;
    localparam int          CTRL_SUPPLY_3V = 0;
    localparam int          CTRL_MIDSCALE  = 1;
    localparam int          ST_MODE_LO  = 16;
    localparam int          ST_LOADED   = 18;
    localparam int          ST_VALID    = 19;
    localparam int          ST_FSM_LO   = 20;

    // serial pins as seen by the port
    typedef struct packed {
        logic sync_n;
        logic sclk;
        logic din;
    } dsw_pins_t;

    // controls for the analog output stage
    typedef struct packed {
        logic amp_en;
        logic out_open;
        logic out_100k;
        logic out_1k;
        logic out_valid;
    } dsw_analog_t;

    // wake time in cycles for the chosen supply
    function automatic logic [5:0] wake_cycles(input logic supply_3v);
        return supply_3v ? WAKE_3V_CYC : WAKE_5V_CYC;
    endfunction

endpackage

/* File: design/dsw_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module dsw_sync (
    input  wire logic              pclk,     // system clock
    input  wire logic              presetn,  // async reset, active low
    input  wire dsw_pkg::dsw_pins_t d,       // raw pins
    output var  dsw_pkg::dsw_pins_t q        // synchronised pins
);

    dsw_pkg::dsw_pins_t meta_reg;

    // two flops; idle pins read as sync high, clock low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 3'h4;
            q        <= 3'h4;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule

`default_nettype wire

/* File: design/dsw_port.sv */
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - frame open only while sync low
// - shift one bit per falling sclk
// - 24th falling edge executes the command
// - bits 17..16 select mode, rest zero
// - low sixteen bits load converter code
// - early sync rise discards the frame
// - power-up code zero, output zero/mid
// - all-ones word is software reset
// - started software reset ignores early rise
// - mode 00 normal, 01 open, 10/11 resistors
// - power-down disconnects amplifier from pin
// - power-down keeps converter code unchanged; here a power-down frame also loads bits 15..0
// - wake takes 2.5 us or 5 us
// - first bit received is bit 23
module dsw_port (
    input  wire logic                pclk,      // system clock, 10 MHz
    input  wire logic                presetn,   // async reset, active low
    input  wire logic                psel,      // apb select
    input  wire logic                penable,   // apb access phase
    input  wire logic                pwrite,    // apb write
    input  wire logic [11:0]         paddr,     // apb byte address
    input  wire logic [31:0]         pwdata,    // apb write data
    output var  logic [31:0]         prdata,    // apb read data
    output var  logic                pready,    // apb ready
    output var  logic                pslverr,   // apb error on unmapped
    input  wire logic                sync_n,    // frame select pin
    input  wire logic                sclk,      // serial clock pin
    input  wire logic                din,       // serial data pin
    output var  logic [15:0]         dac_code,  // code presented to the core
    output var  dsw_pkg::dsw_mode_t  out_mode,  // active output mode
    output var  dsw_pkg::dsw_analog_t analog    // output stage controls
);

    dsw_pkg::dsw_pins_t  pins_s;
    dsw_pkg::dsw_state_t state_reg, state_next;
    dsw_pkg::dsw_mode_t  mode_reg, mode_next;
    logic                sclk_d_reg;
    logic [23:0]         shift_reg, shift_next;
    logic [4:0]          bitcnt_reg, bitcnt_next;
    logic [15:0]         code_reg, code_next;
    logic                loaded_reg, loaded_next;
    logic [1:0]          ctrl_reg;
    logic [15:0]         frames_reg;
    logic [5:0]          wake_reg;

    dsw_sync dsw_sync_i (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({sync_n, sclk, din}),
        .q       (pins_s)
    );

    // edge and frame decode, all on synchronised pins
    wire        sclk_fall  = sclk_d_reg & ~pins_s.sclk;
    wire        in_frame   = (state_reg == dsw_pkg::ST_SHIFT);
    wire        shift_en   = in_frame & ~pins_s.sync_n & sclk_fall;
    wire [23:0] word_in    = {shift_reg[22:0], pins_s.din};
    wire        last_bit   = shift_en & (bitcnt_reg == dsw_pkg::LAST_BIT);
    wire        soft_word  = (word_in == dsw_pkg::SOFT_WORD);
    wire [7:0]  head_byte  = 8'(shift_reg >> (bitcnt_reg - dsw_pkg::GUARD_BITS)); // first 8 bits in
    wire        soft_begun = (bitcnt_reg >= dsw_pkg::GUARD_BITS)
                           & (head_byte == dsw_pkg::SOFT_BYTE);
    wire        early_rise = in_frame & pins_s.sync_n;
    wire        soft_late  = early_rise & soft_begun;
    wire        abort      = early_rise & ~soft_begun;
    wire        exec_norm  = last_bit & ~soft_word;
    wire        exec_soft  = (last_bit & soft_word) | soft_late;
    wire        executed   = exec_norm | exec_soft;
    wire        waking     = (mode_reg != dsw_pkg::MODE_NORMAL)
                           & (mode_next == dsw_pkg::MODE_NORMAL);

    // frame state: a frame opens only from a seen high level
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dsw_pkg::ST_WAIT_HIGH: if (pins_s.sync_n) state_next = dsw_pkg::ST_IDLE;
            dsw_pkg::ST_IDLE:      if (!pins_s.sync_n) state_next = dsw_pkg::ST_SHIFT;
            dsw_pkg::ST_SHIFT: begin
                if (early_rise) state_next = dsw_pkg::ST_IDLE;
                else if (executed) state_next = dsw_pkg::ST_WAIT_HIGH;
            end
            default:               state_next = dsw_pkg::ST_WAIT_HIGH;
        endcase
    end

    // shift register and bit count; cleared on abort or at frame end
    assign shift_next  = (!in_frame || early_rise || executed) ? 24'h000000
                       : (shift_en ? word_in : shift_reg);
    assign bitcnt_next = (!in_frame || early_rise || executed) ? 5'h00
                       : (shift_en ? 5'(bitcnt_reg + 5'h01) : bitcnt_reg);

    // command execution; soft reset returns to the power-on state
    assign code_next   = exec_soft ? dsw_pkg::POR_ZERO
                       : (exec_norm ? word_in[15:0] : code_reg);
    assign mode_next   = exec_soft ? dsw_pkg::MODE_NORMAL
                       : (exec_norm ? dsw_pkg::dsw_mode_t'(word_in[dsw_pkg::MODE_HI:dsw_pkg::MODE_LO])
                       : mode_reg);
    assign loaded_next = exec_soft ? 1'b0 : (exec_norm | loaded_reg);

    // serial side state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg  <= dsw_pkg::ST_WAIT_HIGH;
            sclk_d_reg <= 1'b0;
            shift_reg  <= 24'h000000;
            bitcnt_reg <= 5'h00;
            code_reg   <= dsw_pkg::POR_ZERO;
            mode_reg   <= dsw_pkg::MODE_NORMAL;
            loaded_reg <= 1'b0;
        end else begin
            state_reg  <= state_next;
            sclk_d_reg <= pins_s.sclk;
            shift_reg  <= shift_next;
            bitcnt_reg <= bitcnt_next;
            code_reg   <= code_next;
            mode_reg   <= mode_next;
            loaded_reg <= loaded_next;
        end
    end

    // wake timer: output is held invalid after leaving power-down
    wire [5:0] wake_next = waking ? dsw_pkg::wake_cycles(ctrl_reg[dsw_pkg::CTRL_SUPPLY_3V])
                         : ((wake_reg != 6'h00) ? 6'(wake_reg - 6'h01) : 6'h00);

    // output stage decode; code held between frames in power-down, but a power-down frame still loads its code
    wire        pd_any     = (mode_next != dsw_pkg::MODE_NORMAL);
    wire [15:0] por_code   = ctrl_reg[dsw_pkg::CTRL_MIDSCALE] ? dsw_pkg::POR_MID
                                                              : dsw_pkg::POR_ZERO;
    wire [15:0] code_out   = loaded_next ? code_next : por_code;
    dsw_pkg::dsw_analog_t analog_next;
    assign analog_next.amp_en    = ~pd_any;
    assign analog_next.out_open  = (mode_next == dsw_pkg::MODE_OPEN);
    assign analog_next.out_100k  = (mode_next == dsw_pkg::MODE_R100K);
    assign analog_next.out_1k    = (mode_next == dsw_pkg::MODE_R1K);
    assign analog_next.out_valid = ~pd_any & (wake_next == 6'h00);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_reg <= 6'h00;
            dac_code <= dsw_pkg::POR_ZERO;
            out_mode <= dsw_pkg::MODE_NORMAL;
            analog   <= 5'h11;
        end else begin
            wake_reg <= wake_next;
            dac_code <= code_out;
            out_mode <= mode_next;
            analog   <= analog_next;
        end
    end

    // apb decode; one wait-free access phase, data prepared in setup
    wire        apb_setup = psel & ~penable;
    wire        apb_write = psel & penable & pready & pwrite;
    wire        hit_ctrl  = (paddr == dsw_pkg::CTRL_OFS);
    wire        hit_stat  = (paddr == dsw_pkg::STATUS_OFS);
    wire        hit_cnt   = (paddr == dsw_pkg::COUNT_OFS);
    wire        unmapped  = ~(hit_ctrl | hit_stat | hit_cnt);
    wire [31:0] status_w  = {10'h000, state_reg, analog.out_valid, loaded_reg, mode_reg, code_reg};
    wire [31:0] rd_mux    = hit_ctrl ? {30'h00000000, ctrl_reg}
                          : (hit_stat ? status_w
                          : (hit_cnt ? {16'h0000, frames_reg} : 32'h00000000));

    // control register steers supply timing and power-on level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg   <= dsw_pkg::CTRL_RST;
            frames_reg <= 16'h0000;
            prdata     <= 32'h00000000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
        end else begin
            if (apb_write && hit_ctrl) ctrl_reg <= pwdata[1:0];
            if (executed) frames_reg <= 16'(frames_reg + 16'h0001);
            if (apb_setup) prdata <= rd_mux;
            pready     <= apb_setup;
            pslverr    <= apb_setup & unmapped;
        end
    end

    // checks
    sequence s_last_edge;
        shift_en && bitcnt_reg == dsw_pkg::LAST_BIT;
    endsequence

    sequence s_early_abort;
        in_frame && pins_s.sync_n && !soft_begun;
    endsequence

    AST_SHIFT_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
        shift_en && !executed |=> bitcnt_reg == $past(bitcnt_reg) + 5'h01)
        else $error("bit count did not advance on falling edge");

    AST_NO_SHIFT_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        pins_s.sync_n && !in_frame |=> bitcnt_reg == 5'h00)
        else $error("shift count moved outside a frame");

    AST_EXEC_24: assert property (@(posedge pclk) disable iff (!presetn)
        exec_norm |-> bitcnt_reg == 5'h17)
        else $error("command executed before the 24th edge");

    AST_CODE_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        s_last_edge ##0 !soft_word |=> code_reg == $past(word_in[15:0]) ##1 dac_code == code_reg)
        else $error("converter code not loaded from frame");

    AST_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
        s_early_abort |=> $stable(code_reg) && $stable(mode_reg) && shift_reg == 24'h000000)
        else $error("aborted frame changed state");

    AST_SOFT_RESET: assert property (@(posedge pclk) disable iff (!presetn)
        exec_soft |=> code_reg == 16'h0000 && mode_reg == dsw_pkg::MODE_NORMAL && !loaded_reg)
        else $error("software reset did not restore power-on state");

    AST_SOFT_NO_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
        in_frame && pins_s.sync_n && soft_begun |=> frames_reg == $past(frames_reg) + 16'h0001)
        else $error("started software reset was aborted");

    AST_PD_DISCONNECT: assert property (@(posedge pclk) disable iff (!presetn)
        mode_next == dsw_pkg::MODE_R1K |=> !analog.amp_en && analog.out_1k && !analog.out_valid)
        else $error("power-down did not disconnect the amplifier");

    // wake checks; valid returns on the same edge the timer reaches zero
    sequence s_wake_5v;
        waking && !ctrl_reg[dsw_pkg::CTRL_SUPPLY_3V];
    endsequence

    sequence s_wake_3v;
        waking && ctrl_reg[dsw_pkg::CTRL_SUPPLY_3V];
    endsequence

    sequence s_apb_setup;
        psel && !penable;
    endsequence

    AST_WAKE_TIME: assert property (@(posedge pclk) disable iff (!presetn)
        s_wake_5v |=> !analog.out_valid [*8] ##17 !analog.out_valid ##1 analog.out_valid)
        else $error("wake time out of range");

    AST_WAKE_TIME_3V: assert property (@(posedge pclk) disable iff (!presetn)
        s_wake_3v |=> !analog.out_valid [*8] ##42 !analog.out_valid ##1 analog.out_valid)
        else $error("slow supply wake time out of range");

    AST_IGNORE_DONE: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == dsw_pkg::ST_WAIT_HIGH && sclk_fall |=> $stable(code_reg) && bitcnt_reg == 5'h00)
        else $error("clock edge taken after execution");

    // frame open, shift, mode load and code hold checks
    AST_FRAME_OPEN: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == dsw_pkg::ST_IDLE && !pins_s.sync_n |=> in_frame)
        else $error("frame did not open on low frame select");

    AST_WAIT_REOPEN: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == dsw_pkg::ST_WAIT_HIGH && !pins_s.sync_n |=> state_reg == dsw_pkg::ST_WAIT_HIGH)
        else $error("frame reopened without a high pulse");

    AST_ONE_SHIFT: assert property (@(posedge pclk) disable iff (!presetn)
        in_frame && !shift_en && !early_rise |=> $stable(shift_reg))
        else $error("shift register moved without a falling edge");

    AST_MODE_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        s_last_edge ##0 !soft_word |=> mode_reg == $past(word_in[dsw_pkg::MODE_HI:dsw_pkg::MODE_LO]))
        else $error("mode not taken from bits 17 and 16");

    AST_PD_KEEP_CODE: assert property (@(posedge pclk) disable iff (!presetn)
        mode_reg != dsw_pkg::MODE_NORMAL && !executed |=> $stable(code_reg))
        else $error("converter code changed in power-down");

    // output stage checks
    AST_MODE_OPEN: assert property (@(posedge pclk) disable iff (!presetn)
        mode_next == dsw_pkg::MODE_OPEN |=> !analog.amp_en && analog.out_open
            && !analog.out_100k && !analog.out_1k)
        else $error("open mode decoded wrongly");

    AST_MODE_100K: assert property (@(posedge pclk) disable iff (!presetn)
        mode_next == dsw_pkg::MODE_R100K |=> !analog.amp_en && analog.out_100k
            && !analog.out_open && !analog.out_1k)
        else $error("100k mode decoded wrongly");

    AST_NORMAL_AMP: assert property (@(posedge pclk) disable iff (!presetn)
        mode_next == dsw_pkg::MODE_NORMAL |=> analog.amp_en && !analog.out_open
            && !analog.out_100k && !analog.out_1k)
        else $error("normal mode left the amplifier off");

    AST_POR_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
        !loaded_next |=> dac_code == $past(por_code))
        else $error("power-on level not held before first write");

    // register bus checks
    AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
        s_apb_setup |=> pready ##1 !pready)
        else $error("ready not one cycle after setup");

    AST_APB_ERR: assert property (@(posedge pclk) disable iff (!presetn)
        s_apb_setup |=> pslverr == $past(unmapped))
        else $error("error flag does not match address decode");

    AST_CTRL_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        apb_write && hit_ctrl |=> ctrl_reg == $past(pwdata[1:0]))
        else $error("control write not taken");

endmodule

`default_nettype wire

/* File: verification/dsw_host.sv */
`timescale 1ns/100ps
`default_nettype none

module dsw_host (
    input  wire logic pclk,    // bench clock, paces the pins
    output var  logic sync_n,  // frame select, active low
    output var  logic sclk,    // serial clock, idles low
    output var  logic din      // serial data
);
    initial begin
        sync_n = 1'b1;
        sclk   = 1'b0;
        din    = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // n below 24 raises sync early, above 24 clocks spare edges
    task automatic send(input logic [23:0] word, input int n);
        sync_n <= 1'b1;
        hold(2);
        sync_n <= 1'b0;
        hold(2);
        for (int i = 0; i < n; i++) begin
            din  <= word[23 - (i % 24)];
            sclk <= 1'b1;
            hold(4);                              // 800 ns period
            sclk <= 1'b0;
            hold(4);
        end
        din <= ~din;                              // no stale data after the frame
        hold(6);
        sync_n <= 1'b1;
        hold(4);
    endtask
endmodule

`default_nettype wire

/* File: verification/dsw_port_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module dsw_port_tb;
    logic                 pclk;
    logic                 presetn;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [11:0]          paddr;
    logic [31:0]          pwdata;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 sync_n;
    logic                 sclk;
    logic                 din;
    logic [15:0]          dac_code;
    dsw_pkg::dsw_mode_t   out_mode;
    dsw_pkg::dsw_analog_t analog;
    logic [31:0]          rd;
    logic                 err;
    int                   n_fail;
    int                   n_checks;
    int                   exp_cnt;
    int                   k;

    dsw_port dsw_port_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sync_n(sync_n), .sclk(sclk), .din(din), .dac_code(dac_code),
        .out_mode(out_mode), .analog(analog));
    dsw_host dsw_host_i (.pclk(pclk), .sync_n(sync_n), .sclk(sclk), .din(din));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // analog controls follow from the mode; the valid flag is passed in
    task automatic chk_out(input logic [15:0] code, input logic [1:0] mode, input logic valid);
        logic [4:0] exp_an;
        exp_an = {mode == 2'b00, mode == 2'b01, mode == 2'b10, mode == 2'b11, valid};
        chk_reg({11'h0, analog, dac_code}, {11'h0, exp_an, code}, "output stage");
        chk_reg({30'h0, out_mode}, {30'h0, mode}, "output mode");
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_fail++;
            complete_run();
        end
        @(posedge pclk);                                      // idle edge before next setup
    endtask

    // edges until valid again; the frame task returns about ten edges after execution
    task automatic wait_valid(input int wake);
        k = 0;
        while (analog.out_valid !== 1'b1 && k < 100) begin
            @(posedge pclk);
            k++;
        end
        chk_reg({31'h0, k >= wake - 15 && k <= wake - 5}, 32'h1, "wake time");
    endtask

    // watchdog against a hung sequence
    initial begin
        repeat (100000) @(posedge pclk);
        n_fail++;
        complete_run();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        n_fail = 0;
        n_checks = 0;
        exp_cnt = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_out(16'h0000, 2'b00, 1'b1);
        apb(1'b0, dsw_pkg::CTRL_OFS, 32'h0);
        chk_reg(rd, 32'h0, "ctrl after reset");
        apb(1'b0, 12'hff0, 32'h0);
        chk_reg({31'h0, err}, 32'h1, "unmapped error");
        $display("test reset done");

        // spare edges after the 24th must not disturb the result
        dsw_host_i.send(24'h00a5c3, 28);
        exp_cnt++;
        chk_out(16'ha5c3, 2'b00, 1'b1);
        apb(1'b0, dsw_pkg::STATUS_OFS, 32'h0);
        chk_reg(rd & 32'h000fffff, 32'h000ca5c3, "status");
        $display("test data write done");

        for (int m = 1; m < 4; m++) begin
            dsw_host_i.send({6'h00, 2'(m), 16'ha5c3}, 24);
            exp_cnt++;
            chk_out(16'ha5c3, 2'(m), 1'b0);
        end
        dsw_host_i.send(24'h001111, 23);
        chk_out(16'ha5c3, 2'b11, 1'b0);
        $display("test modes and abort done");

        // slow supply: wake lasts 50 cycles
        apb(1'b1, dsw_pkg::CTRL_OFS, 32'h1);
        apb(1'b0, dsw_pkg::CTRL_OFS, 32'h0);
        chk_reg(rd, 32'h1, "ctrl readback");
        dsw_host_i.send(24'h001234, 24);
        exp_cnt++;
        chk_out(16'h1234, 2'b00, 1'b0);
        wait_valid(dsw_pkg::WAKE_3V_CYC);
        $display("test wake done");

        // soft reset cut short after the upper byte still executes
        apb(1'b1, dsw_pkg::CTRL_OFS, 32'h2);
        chk_out(16'h1234, 2'b00, 1'b1);
        dsw_host_i.send(24'hffffff, 12);
        exp_cnt++;
        repeat (30) @(posedge pclk);
        chk_out(16'h8000, 2'b00, 1'b1);
        apb(1'b0, dsw_pkg::STATUS_OFS, 32'h0);
        chk_reg(rd & 32'h00040000, 32'h0, "loaded after soft reset");
        // fast supply wake after a 100k power-down
        dsw_host_i.send({6'h00, 2'b10, 16'h0042}, 24);
        exp_cnt++;
        chk_out(16'h0042, 2'b10, 1'b0);
        dsw_host_i.send(24'h000042, 24);
        exp_cnt++;
        chk_out(16'h0042, 2'b00, 1'b0);
        wait_valid(dsw_pkg::WAKE_5V_CYC);
        apb(1'b0, dsw_pkg::COUNT_OFS, 32'h0);
        chk_reg(rd & 32'h0000ffff, 32'(exp_cnt), "frame count");
        $display("test soft reset done");
        complete_run();
    end
endmodule

`default_nettype wire
